/* rtl/event_flags.sv */
`timescale 1ns/100ps
module event_flags
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [NUM_FLAGS-1:0] set,
  input wire logic [NUM_FLAGS-1:0] clr,
  output logic [NUM_FLAGS-1:0] flags_q
);
  logic [NUM_FLAGS-1:0] flags_d;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the clearing cycle wins so no event is lost
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    always_comb begin
      flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        flags_q[i] <= 1'b0;
      end else begin
        flags_q[i] <= flags_d[i];
      end
    end
  end
endmodule : event_flags

/* rtl/slow_clock_interval_timer.sv */
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
module slow_clock_interval_timer
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq
);
  logic [31:0] mode_q, mode_d;
  logic [31:0] alarm_q, alarm_d;
  logic [NUM_FLAGS-1:0] mask_q, mask_d;
  logic [31:0] count_q, count_d;
  logic [31:0] readdata_q, readdata_d;
  logic waitrequest_q, waitrequest_d;
  logic irq_q, irq_d;
  logic restart_q, restart_d;
  logic do_write;
  logic [31:0] be_mask;
  logic [NUM_FLAGS-1:0] flag_set, flag_clr, flags;
  logic [NUM_FLAGS-1:0] flag_ien;

  timer_link_if lnk ();

  assign lnk.restart = restart_q;
  assign lnk.prescale = mode_q[PRESCALE_LSB +: PRESCALE_W];
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign irq = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  slow_tick_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lnk(lnk.divider)
  );

  event_flags u_flags (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set(flag_set),
    .clr(flag_clr),
    .flags_q(flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the request completes
  always_comb begin
    waitrequest_d = 1'b1;
    readdata_d = readdata_q;
    if ((read | write) & waitrequest_q) begin
      waitrequest_d = 1'b0;
    end
    if (read & waitrequest_q) begin
      unique case (address)
        OFS_MODE: readdata_d = mode_q;
        OFS_STATUS: readdata_d = 32'(flags);
        OFS_VALUE: readdata_d = count_q;
        OFS_ALARM: readdata_d = alarm_q;
        OFS_MASK: readdata_d = 32'(mask_q);
        default: readdata_d = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  // Writes take effect at the edge where waitrequest is seen low
  assign do_write = write & ~waitrequest_q;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};

  //////////////////////////////////////////////////////////////////////////////
  // Control registers and restart strobe
  always_comb begin
    mode_d = mode_q;
    alarm_d = alarm_q;
    mask_d = mask_q;
    restart_d = 1'b0;
    flag_clr = '0;
    if (do_write) begin
      unique case (address)
        OFS_MODE: begin
          mode_d = ((mode_q & ~be_mask) | (writedata & be_mask)) & MODE_STORE_MASK;
          restart_d = writedata[RESTART_BIT] & byteenable[2];
        end
        OFS_STATUS: flag_clr = writedata[NUM_FLAGS-1:0] & {NUM_FLAGS{byteenable[0]}};
        OFS_ALARM: alarm_d = (alarm_q & ~be_mask) | (writedata & be_mask);
        OFS_MASK: begin
          if (byteenable[0]) begin
            mask_d = writedata[NUM_FLAGS-1:0];
          end
        end
        default: ; // Unmapped writes are dropped
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter, events and interrupt
  always_comb begin
    count_d = count_q;
    flag_set = '0;
    if (restart_q) begin
      count_d = 32'h0000_0000;
    end else if (lnk.inc) begin
      count_d = count_q + 32'h0000_0001;
      flag_set[INC_FLAG_BIT] = 1'b1;
      // Alarm fires when the new count reaches the alarm value
      flag_set[ALARM_FLAG_BIT] = (count_d == alarm_q);
    end
    flag_ien[ALARM_FLAG_BIT] = mode_q[ALM_IEN_BIT];
    flag_ien[INC_FLAG_BIT] = mode_q[INC_IEN_BIT];
    irq_d = |(flags & flag_ien & mask_q);
  end

  // State registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= MODE_RESET;
      alarm_q <= ALARM_RESET;
      mask_q <= MASK_RESET;
      count_q <= 32'h0000_0000;
      readdata_q <= 32'h0000_0000;
      waitrequest_q <= 1'b1;
      irq_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      alarm_q <= alarm_d;
      mask_q <= mask_d;
      count_q <= count_d;
      readdata_q <= readdata_d;
      waitrequest_q <= waitrequest_d;
      irq_q <= irq_d;
      restart_q <= restart_d;
    end
  end
endmodule : slow_clock_interval_timer

/* rtl/slow_tick_prescaler.sv */
`timescale 1ns/100ps
module slow_tick_prescaler
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  timer_link_if.divider lnk
);
  logic [11:0] slow_div_q, slow_div_d;
  logic [16:0] presc_cnt_q, presc_cnt_d;
  logic [16:0] period_q, period_d;
  logic inc_q, inc_d;
  logic slow_tick;

  assign lnk.inc = inc_q;

  //////////////////////////////////////////////////////////////////////////////
  // Slow-clock enable and prescaler next state
  always_comb begin
    slow_div_d = slow_div_q + 12'h001;
    slow_tick = 1'b0;
    if (slow_div_q == SLOW_DIV_COUNT - 12'h001) begin
      slow_div_d = 12'h000;
      slow_tick = 1'b1;
    end
    presc_cnt_d = presc_cnt_q;
    period_d = period_q;
    inc_d = 1'b0;
    if (lnk.restart) begin
      slow_div_d = 12'h000;
      presc_cnt_d = 17'h0_0000;
      period_d = (lnk.prescale == '0) ? PRESCALE_ZERO_PERIOD : {1'b0, lnk.prescale};
    end else if (slow_tick) begin
      if (presc_cnt_q == period_q - 17'h0_0001) begin
        presc_cnt_d = 17'h0_0000;
        inc_d = 1'b1;
      end else begin
        presc_cnt_d = presc_cnt_q + 17'h0_0001;
      end
    end
  end

  // Registers; the period only changes on restart so a live field edit cannot glitch a count
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_div_q <= 12'h000;
      presc_cnt_q <= 17'h0_0000;
      period_q <= PRESCALE_ZERO_PERIOD;
      inc_q <= 1'b0;
    end else begin
      slow_div_q <= slow_div_d;
      presc_cnt_q <= presc_cnt_d;
      period_q <= period_d;
      inc_q <= inc_d;
    end
  end
endmodule : slow_tick_prescaler

/* rtl/timer_link_if.sv */
`timescale 1ns/100ps
interface timer_link_if;
  import timer_pkg::*;
  logic restart;
  logic [PRESCALE_W-1:0] prescale;
  logic inc;
  modport ctrl (output restart, output prescale, input inc);
  modport divider (input restart, input prescale, output inc);
endinterface : timer_link_if

/* rtl/timer_pkg.sv */
package timer_pkg;
  // Clock rates and the slow-clock enable divider
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam logic [11:0] SLOW_DIV_COUNT = 12'((REF_CLK_HZ + SLOW_CLK_HZ / 2) / SLOW_CLK_HZ);

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VALUE = 8'h08;
  localparam logic [7:0] OFS_ALARM = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Mode register fields
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 16;
  localparam int ALM_IEN_BIT = 16;
  localparam int INC_IEN_BIT = 17;
  localparam int RESTART_BIT = 18;
  localparam logic [31:0] MODE_STORE_MASK = 32'h0003_FFFF;

  // Status and mask fields
  localparam int ALARM_FLAG_BIT = 0;
  localparam int INC_FLAG_BIT = 1;
  localparam int NUM_FLAGS = 2;

  // Prescaler period for a zero field, and reset values
  localparam logic [16:0] PRESCALE_ZERO_PERIOD = 17'h1_0000;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] ALARM_RESET = 32'hFFFF_FFFF;
  localparam logic [1:0] MASK_RESET = 2'h0;
endpackage : timer_pkg

/* verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import timer_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata, rd;
  logic waitrequest, irq;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t1;
  localparam int TICK = int'(SLOW_DIV_COUNT);
  slow_clock_interval_timer slow_clock_interval_timer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle count for period measurements
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : check
  // One Avalon transfer; request held until waitrequest is seen low, and only the watchdog ends a hung wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // One wait cycle per request, so the answer is seen at the second edge
    check(32'(n), 32'h0000_0002, "bus wait cycles");
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    check(rd, exp, msg);
  endtask : rdc
  // Bounded wait for a level on the interrupt line
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (irq !== lvl && n < 20000);
    check({31'h0, irq}, {31'h0, lvl}, "irq level");
  endtask : wait_irq
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rdc(OFS_MODE, MODE_RESET, "mode reset");
    rdc(OFS_VALUE, 32'h0000_0000, "count reset");
    rdc(OFS_STATUS, 32'h0000_0000, "flags reset");
    rdc(8'h14, 32'h0000_0000, "unmapped");
    check({31'h0, irq}, 32'h0, "irq reset");
    $display("test_reset done");
  endtask : test_reset
  // Byte lanes: a one-lane write touches only its byte, and restart needs its own lane
  task automatic test_regs();
    byteenable <= 4'h2;
    bus(1'b1, OFS_ALARM, 32'h0000_5A00);
    rdc(OFS_ALARM, 32'hFFFF_5AFF, "alarm lane");
    byteenable <= 4'h3;
    bus(1'b1, OFS_MODE, 32'h0007_0005);
    rdc(OFS_MODE, 32'h0000_0005, "mode lanes");
    byteenable <= 4'hF;
    bus(1'b1, OFS_ALARM, ALARM_RESET);
    bus(1'b1, OFS_MASK, 32'h0000_0003);
    rdc(OFS_MASK, 32'h0000_0003, "mask readback");
    rdc(OFS_VALUE, 32'h0000_0000, "no restart");
    $display("test_regs done");
  endtask : test_regs
  // Prescale 2: exact spacing of increments, flag and gating
  task automatic test_period();
    bus(1'b1, OFS_MASK, 32'h0000_0002);
    bus(1'b1, OFS_MODE, 32'h0006_0002);
    wait_irq(1'b1);
    t1 = cyc;
    rdc(OFS_VALUE, 32'h0000_0001, "first advance");
    rdc(OFS_STATUS, 32'h0000_0002, "inc flag");
    bus(1'b1, OFS_STATUS, 32'h0000_0002);
    wait_irq(1'b0);
    wait_irq(1'b1);
    check(32'(cyc - t1), 32'(2 * TICK), "period");
    bus(1'b1, OFS_MODE, 32'h0000_0002);
    wait_irq(1'b0);
    rdc(OFS_STATUS, 32'h0000_0002, "flag kept");
    $display("test_period done");
  endtask : test_period
  // Restart clears the count; alarm at count one
  task automatic test_alarm();
    bus(1'b1, OFS_MASK, 32'h0000_0001);
    bus(1'b1, OFS_ALARM, 32'h0000_0001);
    bus(1'b1, OFS_MODE, 32'h0005_0001);
    bus(1'b1, OFS_STATUS, 32'h0000_0003);
    rdc(OFS_VALUE, 32'h0000_0000, "restart clear");
    wait_irq(1'b1);
    rdc(OFS_STATUS, 32'h0000_0003, "both flags");
    bus(1'b1, OFS_STATUS, 32'h0000_0001);
    wait_irq(1'b0);
    $display("test_alarm done");
  endtask : test_alarm
  // Zero field means a very long period, so nothing advances soon
  task automatic test_zero();
    bus(1'b1, OFS_MODE, 32'h0004_0000);
    repeat (3 * TICK) @(posedge ref_clk);
    rdc(OFS_VALUE, 32'h0000_0000, "zero prescale");
    $display("test_zero done");
  endtask : test_zero
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly 25000 cycles the tests need
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_regs();
    test_period();
    test_alarm();
    test_zero();
    tally_and_finish();
  end
endmodule : tb_top

/* verification/timer_sva.sv */
`timescale 1ns/100ps
module timer_sva
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [23:0] mode_q, mode_d;
  logic [1:0] mask_q, mask_d;
  logic wr_ok, rd_ok, en;
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of the enables as last written; lanes matter, so a partial write cannot fool it
  always_comb begin
    wr_ok = write && !waitrequest;
    rd_ok = read && !waitrequest;
    mode_d = mode_q;
    mask_d = mask_q;
    for (int b = 0; b < 3; b++) begin
      if (wr_ok && address == OFS_MODE && byteenable[b]) begin
        mode_d[b*8 +: 8] = writedata[b*8 +: 8];
      end
    end
    if (wr_ok && address == OFS_MASK && byteenable[0]) begin
      mask_d = writedata[1:0];
    end
    en = (mode_q[16] && mask_q[0]) || (mode_q[17] && mask_q[1]);
  end
  // Registers of the shadow
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= 24'h00_0000;
      mask_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      mask_q <= mask_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // register access timing, readback values and interrupt gating
  a_wait_one_low: assert property (!waitrequest |=> waitrequest) else $error("answer held too long");
  a_wait_answers: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  a_wait_caused: assert property ($fell(waitrequest) |-> $past(read || write)) else $error("answer unasked");
  a_mode_readback: assert property (rd_ok && address == OFS_MODE |-> readdata == {14'h0, mode_q[17:0]})
    else $error("mode readback wrong");
  a_status_rsvd: assert property (rd_ok && address == OFS_STATUS |-> readdata[31:2] == 30'h0)
    else $error("status reserved bits set");
  a_unmapped_zero: assert property (rd_ok && address > OFS_MASK |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_gated: assert property (irq |-> $past(en)) else $error("irq without enable");
  a_irq_falls: assert property ($fell(irq) |-> $past(wr_ok, 2)) else $error("irq fell unprompted");
endmodule : timer_sva
bind slow_clock_interval_timer timer_sva timer_sva_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .irq(irq));
